// File: verilog/uec_pkg.sv
// Notes on behaviour
// (RL1) Control endpoints: bank handshake and rw-allowed unused, both read 0.
// (RL2) IN: handshake set when current bank frees, with transmitted-IN flag.
// (RL3) IN: clearing handshake queues the bank to send and moves to next bank.
// (RL4) OUT: handshake set when current bank fills, with received-OUT flag.
// (RL5) OUT: clearing handshake frees the current bank and moves to next bank.
// (RL6) Kill set bit starts discarding last written IN bank; hardware clears.
// (RL7) Software waits for kill bit low before handling another IN packet.
// (RL8) Real discard drops busy-bank count by one, no transmitted-IN flag.
// (RL9) Bank sent by racing IN token: count drops, transmitted-IN flag set.
// (RL10) Two banks ready with kill: first is sent, last is discarded.
// (RL11) Busy-bank enable set and cleared by its set and clear bits.
// (RL12) Each event enable: set bit sets, clear bit clears, gates its event.
// (RL13) Clear register: a one clears the control bit, a zero does nothing.
// (RL14) Set register: a one sets the control bit, a zero does nothing.
// (RL15) Shared enable bits; endpoint type picks SETUP/underflow, stall/CRC.
// (RL16) Software clears transmitted-IN flag before clearing the handshake.
// (RL17) Stall request answers STALL; cleared when a new SETUP arrives.
// (RL18) Interrupt asserted while any event flag and its enable are set.
package uec_pkg;
    localparam logic [11:0] A_STA     = 12'h130;
    localparam logic [11:0] A_STA_CLR = 12'h160;
    localparam logic [11:0] A_STA_SET = 12'h190;
    localparam logic [11:0] A_CTL     = 12'h1c0;
    localparam logic [11:0] A_CTL_SET = 12'h1f0;
    localparam logic [11:0] A_CTL_CLR = 12'h220;
    localparam logic [11:0] A_STRIDE  = 12'h004;

    localparam int B_TXIN  = 0;
    localparam int B_RXOUT = 1;
    localparam int B_SHR2  = 2;
    localparam int B_NAKO  = 3;
    localparam int B_NAKI  = 4;
    localparam int B_OVF   = 5;
    localparam int B_SHR6  = 6;
    localparam int B_SHORT = 7;
    localparam int B_BUSY  = 12;
    localparam int B_KILL  = 13;
    localparam int B_HS    = 14;
    localparam int B_RSTDT = 18;
    localparam int B_STALL = 19;
    localparam int B_CNT   = 16;
    localparam int B_RW_ALLOWED = 18;

    localparam logic [31:0] EN_MASK  = 32'h000110ff;
    localparam logic [31:0] EVT_MASK = 32'h000010ff;
    localparam logic [31:0] RST_VAL  = 32'h00000000;

    localparam logic [1:0] EPT_CTRL = 2'h0;
    localparam logic [1:0] EPT_ISO  = 2'h1;

    typedef struct packed {
        logic setup_rx;
        logic short_pkt;
        logic stalled;
        logic crc_err;
        logic overflow;
        logic nak_in;
        logic nak_out;
        logic underflow;
        logic out_full;
        logic in_sent;
    } uec_evt_t;

    typedef struct packed {
        logic bank_send;
        logic bank_free;
        logic bank_kill;
        logic toggle_rst;
    } uec_act_t;

    typedef enum logic [0:0] {
        UEC_IDLE = 1'h0,
        UEC_ARM  = 1'h1
    } uec_kill_t;
endpackage

// File: verilog/uec_endpoint.sv
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
module uec_endpoint #(
    parameter int EP_INDEX  = 0,
    parameter int NUM_BANKS = 2
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic [1:0]        ep_type,
    input  wire logic              ep_dir_in,
    input  wire uec_pkg::uec_evt_t evt,
    output uec_pkg::uec_act_t      act,
    output logic                   stall_out,
    output logic      [1:0]        busy_count,
    output logic                   irq
);
    localparam int CW = 2;
    localparam logic [CW-1:0] NB = CW'(NUM_BANKS);
    localparam logic [CW-1:0] ONE = 2'h1;
    localparam logic [11:0] OFS = 12'(EP_INDEX * 4);

    generate
        if (NUM_BANKS < 1 || NUM_BANKS > 3 || EP_INDEX < 0 ||
            EP_INDEX > 11) begin : g_chk
            $error("uec_endpoint: unsupported parameters");
        end
    endgenerate

    logic                wr_pend_r;
    logic [11:0]         wr_addr_r;
    logic                rd_pend_r;
    logic [11:0]         rd_addr_r;
    logic [31:0]         sta_r;
    logic [31:0]         en_r;
    logic                hs_r;
    logic                stall_r;
    logic [CW-1:0]       busy_r;
    uec_pkg::uec_kill_t  kst_r;
    uec_pkg::uec_act_t   act_r;
    logic                irq_r;
    logic [31:0]         hrdata_r;
    logic                hready_r;

    logic                is_ctrl;
    logic                is_in;
    logic                is_out;
    logic [31:0]         ctl_set;
    logic [31:0]         ctl_clr;
    logic [31:0]         sta_set;
    logic [31:0]         sta_clr;
    logic                sw_send;
    logic                sw_free;
    logic                in_ev;
    logic                tx_dec;
    logic [CW-1:0]       busy_tx;
    logic                discard;
    logic [CW-1:0]       busy_nxt;
    logic [31:0]         ev_now;
    logic [31:0]         sta_nxt;
    logic [31:0]         en_nxt;
    logic                rw_allowed;
    logic [31:0]         ctl_view;
    logic [31:0]         sta_view;
    logic [31:0]         rd_val;
    logic                take;

    assign is_ctrl = (ep_type == uec_pkg::EPT_CTRL);
    assign is_in   = !is_ctrl && ep_dir_in;
    assign is_out  = !is_ctrl && !ep_dir_in;

    // Bus address phase capture
    assign take = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else if (hready_r) begin
            wr_pend_r <= take && hwrite;
            wr_addr_r <= haddr[11:0];
        end
    end

    // Reads take one wait state so earlier writes are visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_r <= 1'b0;
            rd_addr_r <= 12'h000;
            hready_r  <= 1'b1;
            hrdata_r  <= 32'h00000000;
        end else if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
            hready_r  <= 1'b1;
            hrdata_r  <= rd_val;
        end else if (hready_r && take && !hwrite) begin
            rd_pend_r <= 1'b1;
            rd_addr_r <= haddr[11:0];
            hready_r  <= 1'b0;
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp     = 1'b0;

    // Write-only set and clear strobes
    always_comb begin
        ctl_set = 32'h00000000;
        ctl_clr = 32'h00000000;
        sta_set = 32'h00000000;
        sta_clr = 32'h00000000;
        if (wr_pend_r) begin
            if (wr_addr_r == uec_pkg::A_CTL_SET + OFS) begin
                ctl_set = hwdata; // [RL14]
            end
            if (wr_addr_r == uec_pkg::A_CTL_CLR + OFS) begin
                ctl_clr = hwdata; // [RL13]
            end
            if (wr_addr_r == uec_pkg::A_STA_SET + OFS) begin
                sta_set = hwdata & uec_pkg::EVT_MASK;
            end
            if (wr_addr_r == uec_pkg::A_STA_CLR + OFS) begin
                sta_clr = hwdata & uec_pkg::EVT_MASK;
            end
        end
    end

    // Bank bookkeeping
    assign sw_send = is_in && ctl_clr[uec_pkg::B_HS] && hs_r &&
                     (busy_r < NB); // [RL3]
    assign sw_free = is_out && ctl_clr[uec_pkg::B_HS] &&
                     (busy_r != 2'h0); // [RL5]
    // A free bank reported by the far side sets handshake and flag even when
    // no bank is busy; otherwise an IN endpoint could never be loaded.
    assign in_ev   = is_in && evt.in_sent;
    assign tx_dec  = in_ev && (busy_r != 2'h0);
    assign busy_tx = busy_r - (tx_dec ? ONE : 2'h0);
    // A racing IN token empties a single bank first; nothing left to kill
    assign discard = (kst_r == uec_pkg::UEC_ARM) &&
                     (busy_tx != 2'h0); // [RL9] [RL10]

    always_comb begin
        busy_nxt = busy_tx;
        if (sw_send || (is_out && evt.out_full && busy_r < NB)) begin
            busy_nxt = busy_nxt + ONE;
        end
        if (sw_free || discard) begin
            busy_nxt = busy_nxt - ONE; // [RL8]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_r <= 2'h0;
        end else begin
            busy_r <= busy_nxt;
        end
    end

    // Kill procedure
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kst_r <= uec_pkg::UEC_IDLE;
        end else begin
            unique case (kst_r)
                uec_pkg::UEC_IDLE: begin
                    if (is_in && ctl_set[uec_pkg::B_KILL]) begin
                        kst_r <= uec_pkg::UEC_ARM; // [RL6]
                    end
                end
                uec_pkg::UEC_ARM: begin
                    kst_r <= uec_pkg::UEC_IDLE; // [RL6]
                end
            endcase
        end
    end

    // Bank handshake; a hardware set wins over a software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_r <= 1'b0;
        end else if (is_ctrl) begin
            hs_r <= 1'b0; // [RL1]
        end else if (in_ev || (is_out && evt.out_full)) begin
            hs_r <= 1'b1; // [RL2] [RL4]
        end else if (ctl_clr[uec_pkg::B_HS]) begin
            hs_r <= 1'b0; // [RL3] [RL5]
        end
    end

    // Stall request; software set wins over SETUP clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stall_r <= 1'b0;
        end else if (ctl_set[uec_pkg::B_STALL]) begin
            stall_r <= 1'b1; // [RL17]
        end else if (evt.setup_rx || ctl_clr[uec_pkg::B_STALL]) begin
            stall_r <= 1'b0; // [RL17]
        end
    end

    // Enables: set beats clear
    assign en_nxt = ((en_r & ~ctl_clr) | ctl_set) &
                    uec_pkg::EN_MASK; // [RL11] [RL12]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_r <= uec_pkg::RST_VAL;
        end else begin
            en_r <= en_nxt;
        end
    end

    // Event flags
    always_comb begin
        ev_now = 32'h00000000;
        ev_now[uec_pkg::B_TXIN]  = in_ev; // [RL2] [RL9]
        ev_now[uec_pkg::B_RXOUT] = is_out && evt.out_full; // [RL4]
        ev_now[uec_pkg::B_SHR2]  = is_ctrl ? evt.setup_rx
                                           : evt.underflow; // [RL15]
        ev_now[uec_pkg::B_NAKO]  = evt.nak_out;
        ev_now[uec_pkg::B_NAKI]  = evt.nak_in;
        ev_now[uec_pkg::B_OVF]   = evt.overflow;
        ev_now[uec_pkg::B_SHR6]  = (ep_type == uec_pkg::EPT_ISO)
                                   ? evt.crc_err : evt.stalled; // [RL15]
        ev_now[uec_pkg::B_SHORT] = evt.short_pkt;
        ev_now[uec_pkg::B_BUSY]  = (busy_nxt != busy_r);
    end

    assign sta_nxt = (sta_r & ~sta_clr) | sta_set | ev_now;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sta_r <= uec_pkg::RST_VAL;
            irq_r <= 1'b0;
        end else begin
            sta_r <= sta_nxt;
            irq_r <= |(sta_nxt & en_nxt & uec_pkg::EVT_MASK); // [RL18]
        end
    end

    // Actions toward the transceiver side
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_r <= '0;
        end else begin
            act_r.bank_send  <= sw_send; // [RL3]
            act_r.bank_free  <= sw_free; // [RL5]
            act_r.bank_kill  <= discard; // [RL8]
            act_r.toggle_rst <= ctl_set[uec_pkg::B_RSTDT];
        end
    end

    assign act        = act_r;
    assign stall_out  = stall_r;
    assign busy_count = busy_r;
    assign irq        = irq_r;

    // Read views
    assign rw_allowed = is_in ? (busy_r < NB) : (is_out && busy_r != 2'h0);

    always_comb begin
        ctl_view = en_r;
        ctl_view[uec_pkg::B_KILL]  = (kst_r == uec_pkg::UEC_ARM);
        ctl_view[uec_pkg::B_HS]    = hs_r && !is_ctrl; // [RL1]
        ctl_view[uec_pkg::B_STALL] = stall_r;
        sta_view = sta_r;
        sta_view[uec_pkg::B_CNT +: CW] = busy_r;
        sta_view[uec_pkg::B_RW_ALLOWED] = rw_allowed && !is_ctrl; // [RL1]
    end

    always_comb begin
        rd_val = 32'h00000000;
        if (rd_addr_r == uec_pkg::A_CTL + OFS) begin
            rd_val = ctl_view;
        end else if (rd_addr_r == uec_pkg::A_STA + OFS) begin
            rd_val = sta_view;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence kill_req_s;
        kst_r == uec_pkg::UEC_IDLE && is_in && ctl_set[uec_pkg::B_KILL];
    endsequence
    sequence kill_done_s;
        kst_r == uec_pkg::UEC_ARM ##1 kst_r == uec_pkg::UEC_IDLE;
    endsequence

    ctrl_reads_zero_a: assert property ( // [RL1]
        is_ctrl |-> !ctl_view[uec_pkg::B_HS] && !sta_view[uec_pkg::B_RW_ALLOWED])
        else $error("handshake or rw bit visible on control endpoint");
    in_free_hs_a: assert property ( // [RL2]
        (is_in && evt.in_sent && busy_r != 2'h0 && !is_ctrl)
        |=> hs_r && sta_r[uec_pkg::B_TXIN])
        else $error("IN bank free did not set handshake and flag");
    in_send_a: assert property ( // [RL3]
        sw_send |=> act.bank_send)
        else $error("handshake clear did not queue the IN bank");
    out_full_hs_a: assert property ( // [RL4]
        (is_out && evt.out_full) |=> hs_r && sta_r[uec_pkg::B_RXOUT])
        else $error("OUT bank full did not set handshake and flag");
    out_free_a: assert property ( // [RL5]
        sw_free && !(is_out && evt.out_full) |=>
        busy_r == $past(busy_r) - ONE && act.bank_free)
        else $error("OUT handshake clear did not free a bank");
    kill_seq_a: assert property ( // [RL6]
        kill_req_s |=> kill_done_s)
        else $error("kill bit not cleared after one cycle");
    kill_drop_a: assert property ( // [RL8]
        discard && !tx_dec && !sw_send |=>
        busy_r == $past(busy_r) - ONE && !sta_r[uec_pkg::B_TXIN] ||
        $past(sta_r[uec_pkg::B_TXIN]) || $past(sta_set[uec_pkg::B_TXIN]))
        else $error("discard set transmitted flag or kept count");
    kill_race_a: assert property ( // [RL9]
        kst_r == uec_pkg::UEC_ARM && tx_dec && busy_r == ONE
        |-> !discard ##1 busy_count == 2'h0)
        else $error("racing IN token handled as a discard");
    two_bank_a: assert property ( // [RL10]
        kst_r == uec_pkg::UEC_ARM && tx_dec && busy_r == 2'h2 && !sw_send
        |-> discard ##1 busy_count == 2'h0)
        else $error("two ready banks not sent and killed");
    en_set_clr_a: assert property ( // [RL11]
        (ctl_set[uec_pkg::B_BUSY] |=> en_r[uec_pkg::B_BUSY]) and
        (ctl_clr[uec_pkg::B_BUSY] && !ctl_set[uec_pkg::B_BUSY]
        |=> !en_r[uec_pkg::B_BUSY]))
        else $error("busy-bank enable not following set and clear");
    stall_clear_a: assert property ( // [RL17]
        evt.setup_rx && !ctl_set[uec_pkg::B_STALL] |=> !stall_out)
        else $error("stall request survived a new SETUP");
    irq_gate_a: assert property ( // [RL18]
        |(sta_r & en_r & uec_pkg::EVT_MASK) |-> irq)
        else $error("interrupt low with enabled flag set");
endmodule

// File: verification/uec_host_model.sv
`timescale 1ns/1ps
// Far-side stand-in: emits one event pulse a chosen number of cycles after go
module uec_host_model (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              go,
    input  wire uec_pkg::uec_evt_t pat,
    input  wire logic [3:0]        dly,
    output uec_pkg::uec_evt_t      evt
);
    logic [3:0]        cnt_r;
    logic              armed_r;
    uec_pkg::uec_evt_t pat_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r   <= 4'h0;
            armed_r <= 1'b0;
            pat_r   <= '0;
            evt     <= '0;
        end else if (go) begin
            cnt_r   <= dly;
            armed_r <= 1'b1;
            pat_r   <= pat;
            evt     <= '0;
        end else if (armed_r && cnt_r == 4'h0) begin
            evt     <= pat_r;
            armed_r <= 1'b0;
        end else begin
            evt <= '0;
            if (armed_r) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule

// File: verification/test_usb_device_endpoint_control.sv
`timescale 1ns/1ps
module test_usb_device_endpoint_control;
    localparam logic [11:0] OFS = 12'h004;
    logic              hclk, hresetn, hsel, hwrite, ep_dir_in, go;
    logic [31:0]       haddr, hwdata, hrdata, q;
    logic [1:0]        htrans, ep_type, busy_count;
    logic [2:0]        hsize;
    logic [3:0]        dly;
    logic              hready, hreadyout, hresp, stall_out, irq;
    uec_pkg::uec_evt_t evt, pat;
    uec_pkg::uec_act_t act;
    int                failures, n_checks, n_send, n_free, n_kill;

    assign hready = hreadyout;
    uec_endpoint #(.EP_INDEX(1), .NUM_BANKS(2)) u_dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ep_type(ep_type), .ep_dir_in(ep_dir_in), .evt(evt), .act(act),
        .stall_out(stall_out), .busy_count(busy_count), .irq(irq));
    uec_host_model u_host (.hclk(hclk), .hresetn(hresetn), .go(go),
        .pat(pat), .dly(dly), .evt(evt));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // Counted mid-cycle so no check at a clock edge races the count
    always @(negedge hclk) begin
        if (act.bank_send === 1'b1) n_send++;
        if (act.bank_free === 1'b1) n_free++;
        if (act.bank_kill === 1'b1) n_kill++;
    end

    task automatic results;
        if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            failures++;
            results();
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a + OFS};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        wait_rdy();
        r = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a,
                         input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0, q);
        chk(nm, q & m, e);
    endtask

    task automatic send_evt(input logic [9:0] e, input logic [3:0] d);
        go  <= 1'b1;
        pat <= uec_pkg::uec_evt_t'(e);
        dly <= d;
        @(posedge hclk);
        go <= 1'b0;
        tick(int'(d) + 2);
    endtask

    task automatic rst(input logic [1:0] ty, input logic din);
        @(posedge hclk);
        hresetn   <= 1'b0;
        ep_type   <= ty;
        ep_dir_in <= din;
        repeat (5) @(posedge hclk);
        n_send = 0;
        n_free = 0;
        n_kill = 0;
        hresetn <= 1'b1;
    endtask

    task automatic t_reset;
        rst(2'h2, 1'b1);
        tick(1);
        chk("outs", {25'h0, hresp, irq, stall_out, busy_count, act[1:0]},
            32'h0);
        rdchk("ctl", uec_pkg::A_CTL, 32'hffffffff, 32'h0);
        rdchk("sta", uec_pkg::A_STA, 32'hffffffff, 32'h00040000);
        rdchk("set_rd", uec_pkg::A_CTL_SET, 32'hffffffff, 32'h0);
        rdchk("clr_rd", uec_pkg::A_CTL_CLR, 32'hffffffff, 32'h0);
        rdchk("unmapped", 12'h0fc, 32'hffffffff, 32'h0);
    endtask

    task automatic t_enables;
        rst(2'h2, 1'b1);
        wr(uec_pkg::A_CTL_SET, 32'h000010ff);
        rdchk("en_set", uec_pkg::A_CTL, 32'h000010ff, 32'h10ff);
        wr(uec_pkg::A_CTL_CLR, 32'h00001055);
        rdchk("en_clr", uec_pkg::A_CTL, 32'h000010ff, 32'h00aa);
        wr(uec_pkg::A_CTL_SET, 32'h0);
        wr(uec_pkg::A_CTL_CLR, 32'h0);
        rdchk("en_zero", uec_pkg::A_CTL, 32'h000010ff, 32'h00aa);
    endtask

    task automatic t_irq;
        logic [31:0] b;
        rst(2'h2, 1'b0);
        for (int i = 0; i < 13; i++) begin
            if (i < 8 || i == 12) begin
                b = 32'h1 << i;
                wr(uec_pkg::A_STA_SET, b);
                tick(2);
                chk("irq_mask", {31'h0, irq}, 32'h0);
                wr(uec_pkg::A_CTL_SET, b);
                tick(2);
                chk("irq_on", {31'h0, irq}, 32'h1);
                wr(uec_pkg::A_CTL_CLR, b);
                tick(2);
                chk("irq_off", {31'h0, irq}, 32'h0);
                wr(uec_pkg::A_STA_CLR, b);
            end
        end
    endtask

    task automatic t_evt;
        logic [1:0] ty [8] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
        logic [9:0] ev [8] = '{10'h200, 10'h004, 10'h040, 10'h080,
                               10'h100, 10'h020, 10'h010, 10'h008};
        int         bt [8] = '{2, 2, 6, 6, 7, 5, 4, 3};
        for (int i = 0; i < 8; i++) begin
            rst(ty[i], 1'b0);
            wr(uec_pkg::A_CTL_SET, 32'h000000ff);
            send_evt(ev[i], 4'(i % 4));
            tick(1);
            chk("evt_irq", {31'h0, irq}, 32'h1);
            rdchk("evt_flag", uec_pkg::A_STA, 32'hff, 32'h1 << bt[i]);
        end
    endtask

    task automatic t_ctrl;
        rst(2'h0, 1'b0);
        send_evt(10'h002, 4'h0);
        rdchk("ctl_hs", uec_pkg::A_CTL, 32'h00004000, 32'h0);
        rdchk("ctl_rw", uec_pkg::A_STA, 32'h00040000, 32'h0);
        wr(uec_pkg::A_CTL_SET, 32'h00040000);
        tick(0);
        chk("toggle", {31'h0, act.toggle_rst}, 32'h1);
        wr(uec_pkg::A_CTL_SET, 32'h00080000);
        tick(1);
        chk("stall_on", {31'h0, stall_out}, 32'h1);
        send_evt(10'h200, 4'h1);
        tick(1);
        chk("stall_off", {31'h0, stall_out}, 32'h0);
    endtask

    task automatic t_out;
        rst(2'h2, 1'b0);
        wr(uec_pkg::A_CTL_SET, 32'h00001000);
        send_evt(10'h002, 4'h0);
        chk("out_busy", {30'h0, busy_count}, 32'h1);
        rdchk("out_flag", uec_pkg::A_STA, 32'h2, 32'h2);
        rdchk("out_hs", uec_pkg::A_CTL, 32'h00004000, 32'h00004000);
        chk("busy_irq", {31'h0, irq}, 32'h1);
        send_evt(10'h002, 4'h2);
        send_evt(10'h002, 4'h0);
        chk("out_full", {30'h0, busy_count}, 32'h2);
        wr(uec_pkg::A_STA_CLR, 32'h2);
        wr(uec_pkg::A_CTL_CLR, 32'h00004000);
        tick(2);
        chk("out_rel", {30'h0, busy_count}, 32'h1);
        chk("out_free", 32'(n_free), 32'h1);
    endtask

    task automatic fill_in;
        send_evt(10'h001, 4'h0);
        rdchk("in_hs", uec_pkg::A_CTL, 32'h00004000, 32'h00004000);
        rdchk("in_flag", uec_pkg::A_STA, 32'h1, 32'h1);
        wr(uec_pkg::A_STA_CLR, 32'h1);
        wr(uec_pkg::A_CTL_CLR, 32'h00004000);
        tick(2);
        chk("in_busy", {30'h0, busy_count}, 32'h1);
    endtask

    task automatic t_in_kill;
        rst(2'h2, 1'b1);
        fill_in();
        chk("in_send", 32'(n_send), 32'h1);
        wr(uec_pkg::A_CTL_SET, 32'h00002000);
        rdchk("kill_done", uec_pkg::A_CTL, 32'h00002000, 32'h0);
        chk("kill_busy", {30'h0, busy_count}, 32'h0);
        chk("kill_pulse", 32'(n_kill), 32'h1);
        rdchk("kill_noflag", uec_pkg::A_STA, 32'h1, 32'h0);
        fill_in();
        fork
            wr(uec_pkg::A_CTL_SET, 32'h00002000);
            send_evt(10'h001, 4'h0);
        join
        tick(2);
        chk("race_busy", {30'h0, busy_count}, 32'h0);
        chk("race_nokill", 32'(n_kill), 32'h1);
        rdchk("race_flag", uec_pkg::A_STA, 32'h1, 32'h1);
    endtask

    initial begin
        failures = 0;
        n_checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ep_type = 2'h2;
        ep_dir_in = 1'b0;
        go = 1'b0;
        pat = '0;
        dly = 4'h0;
        t_reset();
        t_enables();
        t_irq();
        t_evt();
        t_ctrl();
        t_out();
        t_in_kill();
        results();
    end
endmodule
